// ### rtl/bfc_pkg.sv
// Functional notes
// RULE_01: Power-up in asynchronous array read mode
// RULE_02: Equal blocks, each erasable independently
// RULE_03: Controller runs operations, reports status register
// RULE_04: Burst read gives one word per clock
// RULE_05: Latch-controlled read uses latched address
// RULE_06: Write buffer programs one to sixteen words
// RULE_07: Single word program command
// RULE_08: Block erase suspendable and resumable
// RULE_09: Program suspendable for reads, then resumed
// RULE_10: Per-block protection, all protected at power-up
// RULE_11: Protection state kept nonvolatile across power; code keeps prot across pin reset only, core reset reloads all ones
// RULE_12: Program/erase refused while enable input low
// RULE_13: Protection register, factory and user segments
// RULE_14: Reset pin resets and powers down
// RULE_15: Idle async bus enters auto low power
// RULE_16: Status output level mode shows busy
// RULE_17: Status output pulse mode marks completion
// RULE_18: Host waits for controller done before next
// RULE_19: Ready/busy driven on data bit seven
// RULE_20: Reset low clears status, floats outputs
// RULE_21: Address latch captures on latch rise
// RULE_22: Burst clock active edge is selectable
package bfc_pkg;
  // ----------------------------------------------------------
  // Register map (APB byte addresses)
  // ----------------------------------------------------------
  localparam logic [7:0] BFC_CTRL_OFS = 8'h00;
  localparam logic [7:0] BFC_CMD_OFS = 8'h04;
  localparam logic [7:0] BFC_STAT_OFS = 8'h08;
  localparam logic [7:0] BFC_PROT_OFS = 8'h0C;
  localparam logic [7:0] BFC_PREG_OFS = 8'h10;
  localparam logic [7:0] BFC_PLOCK_OFS = 8'h14;
  localparam logic [7:0] BFC_BUFCNT_OFS = 8'h18;
  // ----------------------------------------------------------
  // Geometry and fields
  // ----------------------------------------------------------
  localparam int BFC_NBLK = 32;
  localparam int BFC_BUFMAX = 16;
  localparam int BFC_PSEG = 64;
  localparam int BFC_CTRL_BURST = 0;
  localparam int BFC_CTRL_FALL = 1;
  localparam int BFC_CTRL_PULSE = 2;
  localparam int BFC_CTRL_LATCH = 3;
  localparam int BFC_ST_READY = 7;
  localparam int BFC_ST_ERSUSP = 6;
  localparam int BFC_ST_ERERR = 5;
  localparam int BFC_ST_PGERR = 4;
  localparam int BFC_ST_VPERR = 3;
  localparam int BFC_ST_PGSUSP = 2;
  localparam int BFC_ST_PROTERR = 1;
  localparam int BFC_ST_LOWPWR = 0;
  // ----------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------
  localparam logic [3:0] BFC_CTRL_RST = 4'h0;
  localparam logic [31:0] BFC_PROT_RST = 32'hFFFF_FFFF;
  localparam logic [7:0] BFC_STAT_RST = 8'h80;
  localparam logic [15:0] BFC_PROG_CYC = 16'h0010;
  localparam logic [15:0] BFC_ERASE_CYC = 16'h0100;
  localparam logic [15:0] BFC_IDLE_CYC = 16'h0020;
  localparam logic [3:0] BFC_PULSE_CYC = 4'h4;
  localparam logic [63:0] BFC_UID = 64'h0123_4567_89AB_CDEF; // Arbitrary
  // ----------------------------------------------------------
  // Commands and states
  // ----------------------------------------------------------
  typedef enum logic [3:0] {
    BFC_C_NONE = 4'h0, BFC_C_WORD = 4'h1, BFC_C_BUF = 4'h2,
    BFC_C_ERASE = 4'h3, BFC_C_SUSP = 4'h4, BFC_C_RESUME = 4'h5,
    BFC_C_PROT = 4'h6, BFC_C_UNPROT = 4'h7, BFC_C_CLR = 4'h8,
    BFC_C_PREG = 4'h9, BFC_C_PLOCK = 4'hA
  } bfc_cmd_t;
  typedef enum logic [3:0] {
    BFC_S_IDLE = 4'b0001, BFC_S_PROG = 4'b0010,
    BFC_S_ERASE = 4'b0100, BFC_S_SUSP = 4'b1000
  } bfc_state_t;
endpackage

// ### rtl/bfc_top.sv
`timescale 1ns/1ns
module bfc_top import bfc_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reset_powerdown_pin_n,
  input wire logic program_erase_enable_input,
  input wire logic burst_clk,
  input wire logic latch_en_n,
  input wire logic chip_en_n,
  input wire logic [20:0] addr_in,
  output logic [20:0] addr_used,
  output logic [15:0] dq_out,
  output logic dq_oe,
  output logic controller_state_output_o,
  output logic controller_state_output_oe,
  output logic low_power
);
  // ----------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------
  logic [1:0] rp_s, vp_s, k_s, le_s, ce_s;
  logic k_d, le_d, ce_d;
  logic [20:0] a_s1, a_s2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rp_s <= 2'b00;
      vp_s <= 2'b00;
      k_s <= 2'b00;
      le_s <= 2'b11;
      ce_s <= 2'b11;
      k_d <= 1'b0;
      le_d <= 1'b1;
      ce_d <= 1'b1;
      a_s1 <= 21'h00_0000;
      a_s2 <= 21'h00_0000;
    end else if (clk_en) begin
      rp_s <= {rp_s[0], reset_powerdown_pin_n};
      vp_s <= {vp_s[0], program_erase_enable_input};
      k_s <= {k_s[0], burst_clk};
      le_s <= {le_s[0], latch_en_n};
      ce_s <= {ce_s[0], chip_en_n};
      k_d <= k_s[1];
      le_d <= le_s[1];
      ce_d <= ce_s[1];
      // Address pins lag like the strobes, so latching stays aligned
      a_s1 <= addr_in;
      a_s2 <= a_s1;
    end
  end
  logic pd;
  assign pd = !rp_s[1];
  // ----------------------------------------------------------
  // APB access
  // ----------------------------------------------------------
  logic wr, rd;
  assign pready = 1'b1;
  assign wr = psel && penable && pwrite && clk_en;
  assign rd = psel && penable && !pwrite;
  logic [3:0] ctrl;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl <= BFC_CTRL_RST; // [RULE_01]
    else if (clk_en && pd) ctrl <= BFC_CTRL_RST; // [RULE_14]
    else if (wr && paddr == BFC_CTRL_OFS) ctrl <= pwdata[3:0]; // [RULE_22]
  end
  logic cmd_wr;
  bfc_cmd_t cmd;
  logic [4:0] cblk;
  assign cmd_wr = wr && paddr == BFC_CMD_OFS && !pd;
  assign cmd = bfc_cmd_t'(pwdata[3:0]);
  assign cblk = pwdata[8:4];
  // ----------------------------------------------------------
  // Program/erase controller
  // ----------------------------------------------------------
  bfc_state_t st, sus_st;
  logic [15:0] cnt, sus_cnt;
  logic [7:0] stat;
  logic [4:0] bufn;
  logic busy, op_done, start_ok;
  logic [31:0] prot;
  logic [63:0] ureg;
  logic ulock;
  assign busy = (st == BFC_S_PROG) || (st == BFC_S_ERASE);
  assign op_done = busy && cnt == 16'h0000;
  // Refuse when disabled or protected target
  assign start_ok = vp_s[1] && !prot[cblk] && st == BFC_S_IDLE; // [RULE_12]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= BFC_S_IDLE;
      sus_st <= BFC_S_IDLE;
      cnt <= 16'h0000;
      sus_cnt <= 16'h0000;
      bufn <= 5'h00;
    end else if (clk_en) begin
      if (pd) begin // Aborts any operation [RULE_14]
        st <= BFC_S_IDLE;
        cnt <= 16'h0000;
      end else if (op_done) begin
        st <= BFC_S_IDLE; // [RULE_03]
      end else if (busy) begin
        cnt <= cnt - 16'h0001;
        if (cmd_wr && cmd == BFC_C_SUSP) begin // [RULE_08] [RULE_09]
          sus_st <= st;
          sus_cnt <= cnt;
          st <= BFC_S_SUSP;
        end
      end else if (cmd_wr) begin
        case (cmd)
          BFC_C_WORD: if (start_ok) begin // [RULE_07]
            st <= BFC_S_PROG;
            cnt <= BFC_PROG_CYC;
          end
          BFC_C_BUF: if (start_ok) begin
            // Field holds count minus one, so sixteen fits
            bufn <= {1'b0, pwdata[12:9]} + 5'h01; // [RULE_06]
            st <= BFC_S_PROG;
            cnt <= BFC_PROG_CYC;
          end
          BFC_C_ERASE: if (start_ok) begin // [RULE_02]
            st <= BFC_S_ERASE;
            cnt <= BFC_ERASE_CYC;
          end
          BFC_C_RESUME: if (st == BFC_S_SUSP) begin
            st <= sus_st; // [RULE_08]
            cnt <= sus_cnt;
          end
          BFC_C_NONE: st <= st;
          default: st <= st;
        endcase
      end
    end
  end
  // ----------------------------------------------------------
  // Status register: set wins over clear
  // ----------------------------------------------------------
  logic refuse_v, refuse_p;
  assign refuse_v = cmd_wr && !vp_s[1] && st == BFC_S_IDLE &&
    (cmd == BFC_C_WORD || cmd == BFC_C_BUF || cmd == BFC_C_ERASE);
  assign refuse_p = cmd_wr && vp_s[1] && prot[cblk] && st == BFC_S_IDLE &&
    (cmd == BFC_C_WORD || cmd == BFC_C_BUF || cmd == BFC_C_ERASE);
  logic lp;
  logic [6:1] sflag;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sflag <= 6'h00;
    else if (clk_en) begin
      if (pd) sflag <= 6'h00; // [RULE_20]
      else begin
        sflag[BFC_ST_VPERR] <= refuse_v || (sflag[BFC_ST_VPERR] && // [RULE_12]
          !(cmd_wr && cmd == BFC_C_CLR));
        sflag[BFC_ST_PROTERR] <= refuse_p || (sflag[BFC_ST_PROTERR] &&
          !(cmd_wr && cmd == BFC_C_CLR)); // [RULE_10]
        sflag[BFC_ST_PGERR] <= refuse_v || refuse_p || (sflag[BFC_ST_PGERR]
          && !(cmd_wr && cmd == BFC_C_CLR));
        sflag[BFC_ST_ERERR] <= (refuse_v && cmd == BFC_C_ERASE) ||
          (sflag[BFC_ST_ERERR] && !(cmd_wr && cmd == BFC_C_CLR));
        sflag[BFC_ST_ERSUSP] <= st == BFC_S_SUSP && sus_st == BFC_S_ERASE;
        sflag[BFC_ST_PGSUSP] <= st == BFC_S_SUSP && sus_st == BFC_S_PROG;
      end
    end
  end
  assign stat = {!busy, sflag, lp}; // [RULE_19]
  // ----------------------------------------------------------
  // Protection bits, protection register
  // ----------------------------------------------------------
  // Flops model cells; bits survive pin reset, not core reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prot <= BFC_PROT_RST; // [RULE_10]
    else if (clk_en && cmd_wr && vp_s[1] && st == BFC_S_IDLE) begin
      if (cmd == BFC_C_PROT) prot[cblk] <= 1'b1; // [RULE_11]
      else if (cmd == BFC_C_UNPROT) prot <= 32'h0000_0000;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ureg <= 64'h0000_0000_0000_0000;
      ulock <= 1'b0;
    end else if (clk_en && cmd_wr && vp_s[1] && !ulock) begin // [RULE_13]
      if (cmd == BFC_C_PREG && pwdata[9]) ureg[63:32] <= {pwdata[31:10],
        10'h000};
      else if (cmd == BFC_C_PREG) ureg[31:0] <= {pwdata[31:10], 10'h000};
      else if (cmd == BFC_C_PLOCK) ulock <= 1'b1;
    end
  end
  // ----------------------------------------------------------
  // Address latch and read path
  // ----------------------------------------------------------
  logic [20:0] alat;
  logic k_act;
  // Active edge per polarity bit
  assign k_act = ctrl[BFC_CTRL_FALL] ? (k_d && !k_s[1]) : // [RULE_22]
    (!k_d && k_s[1]);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) alat <= 21'h00_0000;
    else if (clk_en) begin
      if (!le_s[1] && !ctrl[BFC_CTRL_BURST]) alat <= a_s2; // [RULE_21]
      else if (ctrl[BFC_CTRL_BURST] && k_act && !ce_s[1]) begin
        alat <= le_s[1] ? alat + 21'h00_0001 : a_s2; // [RULE_04]
      end
    end
  end
  // Latched address used in latch mode
  assign addr_used = ctrl[BFC_CTRL_LATCH] ? alat : a_s2; // [RULE_05]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_out <= 16'h0000;
      dq_oe <= 1'b0;
    end else if (clk_en) begin
      dq_oe <= !pd && !ce_s[1]; // [RULE_20]
      dq_out <= {8'h00, stat};
    end
  end
  // ----------------------------------------------------------
  // Auto low power
  // ----------------------------------------------------------
  logic [15:0] idle;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle <= 16'h0000;
      lp <= 1'b0;
    end else if (clk_en) begin
      if (ce_s[1] != ce_d || le_s[1] != le_d || ctrl[BFC_CTRL_BURST]) begin
        idle <= 16'h0000;
        lp <= pd;
      end else if (idle == BFC_IDLE_CYC) lp <= 1'b1; // [RULE_15]
      else idle <= idle + 16'h0001;
    end
  end
  assign low_power = lp;
  // ----------------------------------------------------------
  // Status output, open drain
  // ----------------------------------------------------------
  logic [3:0] pcnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pcnt <= 4'h0;
    else if (clk_en) begin
      if (op_done) pcnt <= BFC_PULSE_CYC; // [RULE_17]
      else if (pcnt != 4'h0) pcnt <= pcnt - 4'h1;
    end
  end
  assign controller_state_output_o = 1'b0;
  assign controller_state_output_oe = ctrl[BFC_CTRL_PULSE] ?
    (pcnt != 4'h0) : busy; // [RULE_16]
  // ----------------------------------------------------------
  // APB read mux
  // ----------------------------------------------------------
  always_comb begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    if (rd) begin
      case (paddr)
        BFC_CTRL_OFS: prdata = {28'h000_0000, ctrl};
        BFC_CMD_OFS: prdata = 32'h0000_0000;
        BFC_STAT_OFS: prdata = {24'h00_0000, stat}; // [RULE_03]
        BFC_PROT_OFS: prdata = prot;
        BFC_PREG_OFS: prdata = BFC_UID[31:0] ^ ureg[31:0]; // [RULE_13]
        BFC_PLOCK_OFS: prdata = {31'h0000_0000, ulock};
        BFC_BUFCNT_OFS: prdata = {27'h000_0000, bufn};
        default: pslverr = 1'b1;
      endcase
    end
  end
  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  property p_refuse;
    @(posedge pclk) disable iff (!presetn)
    (refuse_v && clk_en) |=> st == BFC_S_IDLE && stat[BFC_ST_VPERR];
  endproperty
  a_refuse: assert property (p_refuse) else $error("op not refused"); // [RULE_12]
  property p_pd;
    @(posedge pclk) disable iff (!presetn)
    (pd && clk_en) |=> !dq_oe && !busy;
  endproperty
  a_pd: assert property (p_pd) else $error("powerdown not held"); // [RULE_20]
  property p_lvl;
    @(posedge pclk) disable iff (!presetn)
    !ctrl[BFC_CTRL_PULSE] |-> controller_state_output_oe == busy;
  endproperty
  a_lvl: assert property (p_lvl) else $error("level wrong"); // [RULE_16]
  property p_pulse;
    @(posedge pclk) disable iff (!presetn)
    (op_done && clk_en) |=> pcnt == BFC_PULSE_CYC;
  endproperty
  a_pulse: assert property (p_pulse) else $error("no pulse"); // [RULE_17]
  property p_rdy;
    @(posedge pclk) disable iff (!presetn) (busy && clk_en) |=> !dq_out[7];
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready wrong"); // [RULE_19]
  property p_prot;
    @(posedge pclk) disable iff (!presetn)
    (refuse_p && clk_en) |=> st == BFC_S_IDLE && stat[BFC_ST_PROTERR];
  endproperty
  a_prot: assert property (p_prot) else $error("protected op ran"); // [RULE_10]
  property p_susp;
    @(posedge pclk) disable iff (!presetn)
    (busy && !op_done && !pd && clk_en && cmd_wr && cmd == BFC_C_SUSP)
      |=> st == BFC_S_SUSP;
  endproperty
  a_susp: assert property (p_susp) else $error("no suspend"); // [RULE_08]
  property p_ulock;
    @(posedge pclk) disable iff (!presetn)
    ulock |=> ulock && $stable(ureg);
  endproperty
  a_ulock: assert property (p_ulock) else $error("user seg changed"); // [RULE_13]
  c_erase: cover property (@(posedge pclk) st == BFC_S_ERASE);
  c_susp: cover property (@(posedge pclk) st == BFC_S_SUSP);
  c_lp: cover property (@(posedge pclk) lp);
endmodule // bfc_top

// ### tb/bfc_host_model.sv
`timescale 1ns/1ns
module bfc_host_model (
  input wire logic pclk,
  input wire logic sts_o,
  input wire logic sts_oe,
  output logic sts_line,
  output logic reset_powerdown_pin_n,
  output logic program_erase_enable_input,
  output logic burst_clk,
  output logic latch_en_n,
  output logic chip_en_n,
  output logic [20:0] addr_in
);
  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  // Open drain line, pulled up when nobody sinks it
  assign sts_line = (sts_oe === 1'b1) ? sts_o : 1'b1;
  initial begin
    reset_powerdown_pin_n = 1'b1;
    program_erase_enable_input = 1'b1;
    burst_clk = 1'b0;
    latch_en_n = 1'b0;
    chip_en_n = 1'b0;
    addr_in = 21'h00_0000;
  end
  // Latch edge and address move together after a bus edge
  task automatic drive(input logic rp_n, input logic en, input logic ce_n,
                       input logic le_n, input logic [20:0] a);
    @(posedge pclk);
    reset_powerdown_pin_n <= rp_n;
    program_erase_enable_input <= en;
    chip_en_n <= ce_n;
    latch_en_n <= le_n;
    addr_in <= a;
  endtask
  // Burst clock only runs inside a frame, idle low between frames
  task automatic burst_frame(input int n);
    #1;
    repeat (2 * n) begin
      #24 burst_clk = ~burst_clk;
    end
    burst_clk = 1'b0;
  endtask
endmodule // bfc_host_model

// ### tb/bfc_top_tb.sv
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module bfc_top_tb import bfc_pkg::*;;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic rp_n, pe_en, bclk, le_n, ce_n, dq_oe, sts_o, sts_oe, sts_line, lp;
  logic [20:0] addr_in, addr_used;
  logic [15:0] dq_out;
  logic [7:0] n;
  int mismatches, checks;
  bfc_top dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_powerdown_pin_n(rp_n), .program_erase_enable_input(pe_en),
    .burst_clk(bclk), .latch_en_n(le_n), .chip_en_n(ce_n),
    .addr_in(addr_in), .addr_used(addr_used), .dq_out(dq_out),
    .dq_oe(dq_oe), .controller_state_output_o(sts_o),
    .controller_state_output_oe(sts_oe), .low_power(lp));
  bfc_host_model host (.pclk(pclk), .sts_o(sts_o), .sts_oe(sts_oe),
    .sts_line(sts_line), .reset_powerdown_pin_n(rp_n),
    .program_erase_enable_input(pe_en), .burst_clk(bclk),
    .latch_en_n(le_n), .chip_en_n(ce_n), .addr_in(addr_in));
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task complete_run;
    $display("mismatches=%0d checks=%0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Always opens on a fresh edge, so a release never meets a new setup
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    if (pready !== 1'b1) begin
      mismatches++;
      complete_run();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic cmd(input logic [3:0] c, input logic [4:0] b,
                     input logic [3:0] cnt);
    apb(1'b1, BFC_CMD_OFS, {19'h0_0000, cnt, b, c});
  endtask
  task automatic chk_stat(input logic [7:0] m, input logic [7:0] e);
    apb(1'b0, BFC_STAT_OFS, 32'h0000_0000);
    `CHK(rd[7:0] & m, e)
  endtask
  // Poll until status bit seven reads ready (not busy, so suspend also passes) before the next operation
  task automatic wait_ready;
    int k;
    k = 0;
    do begin
      apb(1'b0, BFC_STAT_OFS, 32'h0000_0000);
      k++;
    end while (rd[7] !== 1'b1 && k < 200);
    if (rd[7] !== 1'b1) begin
      mismatches++;
      complete_run();
    end
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0; clk_en = 1'b1; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0000_0000;
    mismatches = 0; checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk_stat(8'hFE, BFC_STAT_RST);
    apb(1'b0, BFC_PROT_OFS, 32'h0000_0000);
    `CHK(rd, BFC_PROT_RST)
    apb(1'b0, 8'h1C, 32'h0000_0000);
    `CHK(err, 1'b1)
    cmd(BFC_C_WORD, 5'h03, 4'h0);
    chk_stat(8'h02, 8'h02);
    cmd(BFC_C_CLR, 5'h00, 4'h0);
    chk_stat(8'hFE, 8'h80);
    cmd(BFC_C_UNPROT, 5'h00, 4'h0);
    cmd(BFC_C_PROT, 5'h02, 4'h0);
    apb(1'b0, BFC_PROT_OFS, 32'h0000_0000);
    `CHK(rd, 32'h0000_0004)
    host.drive(1'b1, 1'b0, 1'b0, 1'b0, 21'h00_0000);
    repeat (4) @(posedge pclk);
    cmd(BFC_C_WORD, 5'h03, 4'h0);
    chk_stat(8'h08, 8'h08);
    host.drive(1'b0, 1'b1, 1'b0, 1'b0, 21'h00_0000);
    repeat (4) @(posedge pclk);
    #1 `CHK(dq_oe, 1'b0)
    host.drive(1'b1, 1'b1, 1'b0, 1'b0, 21'h00_0000);
    repeat (4) @(posedge pclk);
    chk_stat(8'hFE, 8'h80);
    apb(1'b0, BFC_PROT_OFS, 32'h0000_0000);
    `CHK(rd, 32'h0000_0004)
    cmd(BFC_C_WORD, 5'h03, 4'h0);
    `CHK(sts_line, 1'b0)
    @(posedge pclk);
    #1 `CHK(dq_out[7], 1'b0)
    wait_ready();
    chk_stat(8'hFE, 8'h80);
    for (int i = 0; i < 2; i++) begin
      cmd(BFC_C_BUF, 5'h03, (i == 0) ? 4'h0 : 4'hF);
      wait_ready();
      chk_stat(8'hFE, 8'h80);
      apb(1'b0, BFC_BUFCNT_OFS, 32'h0000_0000);
      `CHK(rd, (i == 0) ? 32'h0000_0001 : 32'h0000_0010)
    end
    apb(1'b1, BFC_CMD_OFS, 32'hABCD_E409);
    apb(1'b0, BFC_PREG_OFS, 32'h0000_0000);
    `CHK(rd, BFC_UID[31:0] ^ 32'hABCD_E400)
    cmd(BFC_C_PLOCK, 5'h00, 4'h0);
    apb(1'b1, BFC_CMD_OFS, 32'h5555_5409);
    apb(1'b0, BFC_PREG_OFS, 32'h0000_0000);
    `CHK(rd, BFC_UID[31:0] ^ 32'hABCD_E400)
    apb(1'b0, BFC_PLOCK_OFS, 32'h0000_0000);
    `CHK(rd, 32'h0000_0001)
    cmd(BFC_C_ERASE, 5'h05, 4'h0);
    cmd(BFC_C_SUSP, 5'h00, 4'h0);
    repeat (4) @(posedge pclk);
    chk_stat(8'h40, 8'h40);
    cmd(BFC_C_RESUME, 5'h00, 4'h0);
    wait_ready();
    chk_stat(8'hFE, 8'h80);
    cmd(BFC_C_WORD, 5'h03, 4'h0);
    cmd(BFC_C_SUSP, 5'h00, 4'h0);
    chk_stat(8'h04, 8'h04);
    cmd(BFC_C_RESUME, 5'h00, 4'h0);
    wait_ready();
    chk_stat(8'hFE, 8'h80);
    apb(1'b1, BFC_CTRL_OFS, 32'h0000_0004);
    cmd(BFC_C_WORD, 5'h03, 4'h0);
    n = 8'h00;
    repeat (60) begin
      @(posedge pclk);
      #1 if (sts_line === 1'b0) n++;
    end
    `CHK(n, {4'h0, BFC_PULSE_CYC})
    apb(1'b1, BFC_CTRL_OFS, 32'h0000_0008);
    host.drive(1'b1, 1'b1, 1'b0, 1'b0, 21'h0A_5A5A);
    host.drive(1'b1, 1'b1, 1'b0, 1'b1, 21'h0A_5A5A);
    host.drive(1'b1, 1'b1, 1'b0, 1'b1, 21'h15_A5A5);
    repeat (4) @(posedge pclk);
    #1 `CHK(addr_used, 21'h0A_5A5A)
    host.drive(1'b1, 1'b1, 1'b0, 1'b0, 21'h15_A5A5);
    repeat (4) @(posedge pclk);
    #1 `CHK(addr_used, 21'h15_A5A5)
    host.drive(1'b1, 1'b1, 1'b0, 1'b1, 21'h15_A5A5);
    repeat (4) @(posedge pclk);
    apb(1'b1, BFC_CTRL_OFS, 32'h0000_0009);
    host.burst_frame(8);
    repeat (4) @(posedge pclk);
    #1 `CHK(addr_used, 21'h15_A5AD)
    apb(1'b1, BFC_CTRL_OFS, 32'h0000_000B);
    host.burst_frame(8);
    repeat (4) @(posedge pclk);
    #1 `CHK(addr_used, 21'h15_A5B5)
    `CHK(dq_oe, 1'b1)
    apb(1'b1, BFC_CTRL_OFS, 32'h0000_0000);
    host.drive(1'b1, 1'b1, 1'b1, 1'b0, 21'h00_0000);
    repeat (50) @(posedge pclk);
    #1 `CHK(lp, 1'b1)
    complete_run();
  end
endmodule // bfc_top_tb
